// ---- verilog/sec_evt_consts.svh ----
`ifndef SEC_EVT_CONSTS_SVH
`define SEC_EVT_CONSTS_SVH
// Register byte offsets
`define OFS_CORE_STATUS 8'h00
`define OFS_CORE_ENABLE 8'h04
`define OFS_THRESHOLD 8'h08
`define OFS_DROP_STATUS 8'h0c
`define OFS_DROP_ENABLE 8'h10
`define OFS_TARGET_LOW 8'h14
`define OFS_TARGET_HIGH 8'h18
`define OFS_TARGET_CTX 8'h1c
`define OFS_UPDATE_CTRL 8'h20
`define OFS_STAT_CFG 8'h24
// Crypto core status bits
`define BIT_INPUT_ERR 0
`define BIT_OUTPUT_ERR 1
`define BIT_PROC_ERR 2
`define BIT_CTX_ERR 3
`define BIT_SEQ_THR 4
`define BIT_FATAL_ERR 14
// Drop status bits: ingress 0..3, egress 8..10
`define BIT_IG_CLASS 0
`define BIT_IG_CONSIST 1
`define BIT_IG_POST 2
`define BIT_IG_MTU 3
`define BIT_EG_CLASS 8
`define BIT_EG_POST 9
`define BIT_EG_MTU 10
// Reset values
`define RST_THRESHOLD 32'h0000_0000
`define RST_CORE_ENABLE 32'h0000_0000
`define RST_DROP_ENABLE 32'h0000_0000
`endif

// ---- verilog/sec_evt_pkg.sv ----
package sec_evt_pkg;
   typedef enum {UPD_IDLE, UPD_READ, UPD_WRITE} upd_state_e;
   typedef logic [7:0] reg_addr_t;
endpackage

// ---- verilog/sec_evt_irq.sv ----
`timescale 1ns/10ps
// Functional notes
// - Five ingress and four egress interrupt sources
// - Core errors latched; write one clears
// - Short packet sets input error bit 0
// - Hardware faults set bits 1, 2 and 14
// - Flow type mismatch sets processing bit 2
// - Bad transform record sets context bit 3
// - Sequence threshold passed sets warning bit 4
// - Flow lookup drop raises classification interrupt
// - Consistency drop interrupt on ingress only
// - Post-processing drop except MTU raises interrupt
// - MTU oversize drop raises own interrupt
// - Core self-clears update enable when done
// - Update only when stored below requested
// - Lowest acceptable follows, window size kept
// - Egress SA shares one packet counter
// - Frame counters 40 bits, octets 80
// - Counters may clear-on-read and saturate
`include "sec_evt_consts.svh"
module sec_evt_irq #(
   parameter int CTX_W = 8
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire sec_evt_pkg::reg_addr_t addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   // Crypto core event pulses
   input wire logic short_len_err_i,
   input wire logic out_hw_err_i,
   input wire logic proc_hw_err_i,
   input wire logic flow_type_mismatch_i,
   input wire logic ctx_err_i,
   input wire logic fatal_err_i,
   // Sequence number of egress packet being processed
   input wire logic eg_seq_valid_i,
   input wire logic [31:0] eg_seq_i,
   // Drop event pulses
   input wire logic ig_class_drop_i,
   input wire logic ig_consist_drop_i,
   input wire logic ig_post_drop_i,
   input wire logic ig_mtu_drop_i,
   input wire logic eg_class_drop_i,
   input wire logic eg_post_drop_i,
   input wire logic eg_mtu_drop_i,
   // Transform record port for the packet-number update
   output logic [CTX_W-1:0] rec_ctx_o,
   output logic rec_rd_o,
   input wire logic [63:0] rec_seq_i,
   output logic rec_wr_o,
   output logic [63:0] rec_seq_o,
   // Counter behaviour for the statistics store
   output logic stat_clear_on_read_o,
   output logic stat_saturate_o,
   output logic core_irq_o,
   output logic ig_irq_o,
   output logic eg_irq_o,
   output logic irq_o
);
   import sec_evt_pkg::*;

   localparam int FRAME_CNT_W = 40;
   localparam int OCTET_CNT_W = 80;

   logic [31:0] core_status;
   logic [31:0] core_enable;
   logic [31:0] threshold;
   logic [31:0] drop_status;
   logic [31:0] drop_enable;
   logic [31:0] target_low;
   logic [31:0] target_high;
   logic [CTX_W-1:0] target_ctx;
   logic xpn_mode;
   logic update_enable;
   logic [1:0] stat_cfg;
   upd_state_e upd_state;
   logic [31:0] core_set;
   logic [31:0] drop_set;
   logic seq_over;
   logic [63:0] target_full;
   logic core_status_wr;
   logic drop_status_wr;
   logic core_enable_wr;
   logic drop_enable_wr;
   logic threshold_wr;
   logic target_low_wr;
   logic target_high_wr;
   logic target_ctx_wr;
   logic update_ctrl_wr;
   logic stat_cfg_wr;
   logic upd_start;
   logic upd_commit;
   logic [31:0] next_rdata;

   // One decoded strobe per register keeps every register block to a single concern
   assign core_status_wr = wr_i && (addr_i == `OFS_CORE_STATUS);
   assign drop_status_wr = wr_i && (addr_i == `OFS_DROP_STATUS);
   assign core_enable_wr = wr_i && (addr_i == `OFS_CORE_ENABLE);
   assign drop_enable_wr = wr_i && (addr_i == `OFS_DROP_ENABLE);
   assign threshold_wr = wr_i && (addr_i == `OFS_THRESHOLD);
   assign target_low_wr = wr_i && (addr_i == `OFS_TARGET_LOW);
   assign target_high_wr = wr_i && (addr_i == `OFS_TARGET_HIGH);
   assign target_ctx_wr = wr_i && (addr_i == `OFS_TARGET_CTX);
   assign update_ctrl_wr = wr_i && (addr_i == `OFS_UPDATE_CTRL);
   assign stat_cfg_wr = wr_i && (addr_i == `OFS_STAT_CFG);

   // Hardware fault on the processing path shares bit 2 with mismatch
   // Strict compare: a number equal to the threshold has not passed it yet
   assign seq_over = eg_seq_valid_i && (eg_seq_i > threshold);
   always_comb
   begin
      core_set = 32'h0000_0000;
      core_set[`BIT_INPUT_ERR] = short_len_err_i;
      core_set[`BIT_OUTPUT_ERR] = out_hw_err_i;
      core_set[`BIT_FATAL_ERR] = fatal_err_i;
      core_set[`BIT_PROC_ERR] = flow_type_mismatch_i | proc_hw_err_i;
      core_set[`BIT_CTX_ERR] = ctx_err_i;
      core_set[`BIT_SEQ_THR] = seq_over;
   end

   always_comb
   begin
      drop_set = 32'h0000_0000;
      drop_set[`BIT_IG_CLASS] = ig_class_drop_i;
      drop_set[`BIT_EG_CLASS] = eg_class_drop_i;
      drop_set[`BIT_IG_CONSIST] = ig_consist_drop_i;
      drop_set[`BIT_IG_POST] = ig_post_drop_i;
      drop_set[`BIT_EG_POST] = eg_post_drop_i;
      drop_set[`BIT_IG_MTU] = ig_mtu_drop_i;
      drop_set[`BIT_EG_MTU] = eg_mtu_drop_i;
   end

   // One latch per status bit. The set term is kept in the clearing branch too, so an
   // event that lands in the same cycle as the write-one clear survives it.
   for (genvar b = 0; b < 32; b++)
   begin : status_bit
      always_ff @(posedge clk_i or negedge nrst_i)
      begin
         if (!nrst_i)
            core_status[b] <= 1'b0;
         else if (core_status_wr && wdata_i[b])
            core_status[b] <= core_set[b];
         else
            core_status[b] <= core_status[b] | core_set[b];
      end

      always_ff @(posedge clk_i or negedge nrst_i)
      begin
         if (!nrst_i)
            drop_status[b] <= 1'b0;
         else if (drop_status_wr && wdata_i[b])
            drop_status[b] <= drop_set[b];
         else
            drop_status[b] <= drop_status[b] | drop_set[b];
      end
   end

   // Software-owned configuration, one block per register
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         core_enable <= `RST_CORE_ENABLE;
      else if (core_enable_wr)
         core_enable <= wdata_i;
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         drop_enable <= `RST_DROP_ENABLE;
      else if (drop_enable_wr)
         drop_enable <= wdata_i;
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         threshold <= `RST_THRESHOLD;
      else if (threshold_wr)
         threshold <= wdata_i;
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         target_low <= 32'h0000_0000;
      else if (target_low_wr)
         target_low <= wdata_i;
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         target_high <= 32'h0000_0000;
      else if (target_high_wr)
         target_high <= wdata_i;
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         target_ctx <= '0;
      else if (target_ctx_wr)
         target_ctx <= wdata_i[CTX_W-1:0];
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         xpn_mode <= 1'b0;
      else if (update_ctrl_wr)
         xpn_mode <= wdata_i[1];
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         stat_cfg <= 2'h0;
      else if (stat_cfg_wr)
         stat_cfg <= wdata_i[1:0];
   end

   // Clear-on-read and saturation apply alike to every counter, the single shared
   // packet counter of each egress SA included; its meaning follows the SA's cipher mode.
   assign stat_clear_on_read_o = stat_cfg[0];
   assign stat_saturate_o = stat_cfg[1];

   // Without extended numbering the target's high half is forced to zero for the 64-bit compare and write
   assign target_full = xpn_mode ? {target_high, target_low} : {32'h0000_0000, target_low};

   // Update sequencer: read the record, compare, write if larger.
   // A request while busy is dropped rather than queued, so software polls the enable bit.
   assign upd_start = update_ctrl_wr && wdata_i[0] && (upd_state == UPD_IDLE);
   // The record keeps window size, so the lowest acceptable number moves with it.
   assign upd_commit = (upd_state == UPD_WRITE) && (rec_seq_i < target_full);

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         upd_state <= UPD_IDLE;
      else
      begin
         case (upd_state)
            UPD_IDLE:
            begin
               if (upd_start)
                  upd_state <= UPD_READ;
            end
            UPD_READ:
            begin
               upd_state <= UPD_WRITE;
            end
            UPD_WRITE:
            begin
               upd_state <= UPD_IDLE;
            end
            default: upd_state <= UPD_IDLE;
         endcase
      end
   end

   // Completion shows as the enable bit dropping once the record step is over
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         update_enable <= 1'b0;
      else if (upd_start)
         update_enable <= 1'b1;
      else if (upd_state == UPD_WRITE)
         update_enable <= 1'b0;
   end

   // Context latched at the start so a later context write cannot redirect a running update
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         rec_ctx_o <= '0;
      else if (upd_start)
         rec_ctx_o <= target_ctx;
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         rec_rd_o <= 1'b0;
      else
         rec_rd_o <= upd_start;
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         rec_wr_o <= 1'b0;
      else
         rec_wr_o <= upd_commit;
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         rec_seq_o <= 64'h0;
      else if (upd_commit)
         rec_seq_o <= target_full;
   end

   // Unmapped offsets and idle cycles read as zero
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      if (rd_i)
      begin
         case (addr_i)
            `OFS_CORE_STATUS: next_rdata = core_status;
            `OFS_CORE_ENABLE: next_rdata = core_enable;
            `OFS_THRESHOLD: next_rdata = threshold;
            `OFS_DROP_STATUS: next_rdata = drop_status;
            `OFS_DROP_ENABLE: next_rdata = drop_enable;
            `OFS_TARGET_LOW: next_rdata = target_low;
            `OFS_TARGET_HIGH: next_rdata = target_high;
            `OFS_TARGET_CTX: next_rdata = 32'(target_ctx);
            `OFS_UPDATE_CTRL: next_rdata = {30'h0, xpn_mode, update_enable};
            `OFS_STAT_CFG: next_rdata = {30'h0, stat_cfg};
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         rdata_o <= 32'h0000_0000;
      else
         rdata_o <= next_rdata;
   end

   // Crypto core is one source per direction; it raises both line groups
   assign core_irq_o = |(core_status & core_enable);
   assign ig_irq_o = core_irq_o | (|(drop_status[7:0] & drop_enable[7:0]));
   assign eg_irq_o = core_irq_o | (|(drop_status[15:8] & drop_enable[15:8]));
   assign irq_o = ig_irq_o | eg_irq_o;
endmodule

// ---- verif/sec_evt_irq_properties.sv ----
`timescale 1ns/10ps
module sec_evt_chk
   import sec_evt_pkg::*;
#(
   parameter int CTX_W = 8
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire sec_evt_pkg::reg_addr_t addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o,
   input wire logic [CTX_W-1:0] rec_ctx_o,
   input wire logic rec_rd_o,
   input wire logic [63:0] rec_seq_i,
   input wire logic rec_wr_o,
   input wire logic [63:0] rec_seq_o,
   input wire logic core_irq_o,
   input wire logic ig_irq_o,
   input wire logic eg_irq_o,
   input wire logic irq_o
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);
   rd_quiet_a: assert property (!rd_i |=> rdata_o == 32'h0)
      else $error("read data not idle");
   upd_start_a: assert property (rec_rd_o |-> $past(wr_i) && $past(addr_i) == 8'h20)
      else $error("record read without update request");
   upd_gap_a: assert property (rec_rd_o |=> !rec_rd_o [*2])
      else $error("record read repeated");
   upd_order_a: assert property (rec_wr_o |-> $past(rec_rd_o, 2))
      else $error("record write not after read");
   upd_higher_a: assert property (rec_wr_o |-> rec_seq_o > $past(rec_seq_i))
      else $error("record written with lower number");
   upd_ctx_a: assert property (rec_wr_o |-> $stable(rec_ctx_o))
      else $error("context moved during update");
   core_both_a: assert property (core_irq_o |-> ig_irq_o && eg_irq_o)
      else $error("core error missing on a path");
   irq_any_a: assert property (irq_o == (core_irq_o || ig_irq_o || eg_irq_o))
      else $error("irq output not the sum of sources");
   irq_fall_a: assert property ($fell(irq_o) |-> $past(wr_i))
      else $error("irq dropped without software write");
endmodule
bind sec_evt_irq sec_evt_chk #(.CTX_W(CTX_W)) chk_i (.clk_i(clk_i), .nrst_i(nrst_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .rec_ctx_o(rec_ctx_o), .rec_rd_o(rec_rd_o), .rec_seq_i(rec_seq_i), .rec_wr_o(rec_wr_o),
   .rec_seq_o(rec_seq_o), .core_irq_o(core_irq_o), .ig_irq_o(ig_irq_o),
   .eg_irq_o(eg_irq_o), .irq_o(irq_o));

// ---- verif/sec_evt_irq_tb_top.sv ----
`timescale 1ns/10ps
module sec_evt_irq_tb_top;
   import sec_evt_pkg::*;
   logic clk_i = 0;
   logic nrst_i = 0;
   reg_addr_t addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0;
   logic wr_i = 0;
   logic rd_i = 0;
   logic [5:0] cev = 6'h0;
   logic [6:0] dev = 7'h0;
   logic seq_v = 0;
   logic [31:0] seq = 32'h0;
   logic [63:0] rec_seq_i = 64'h0;
   logic [31:0] rdata_o;
   logic [7:0] rec_ctx_o;
   logic [63:0] rec_seq_o;
   logic rec_rd_o, rec_wr_o, cor_o, sat_o, core_irq_o, ig_irq_o, eg_irq_o, irq_o;
   int err_count = 0;
   int check_count = 0;
   int cyc = 0;
   int cb[6] = '{0, 1, 2, 2, 3, 14};
   int db[7] = '{0, 1, 2, 3, 8, 9, 10};
   always #4 clk_i = ~clk_i;
   sec_evt_irq #(.CTX_W(8)) dut (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .short_len_err_i(cev[0]), .out_hw_err_i(cev[1]), .proc_hw_err_i(cev[2]),
      .flow_type_mismatch_i(cev[3]), .ctx_err_i(cev[4]), .fatal_err_i(cev[5]),
      .eg_seq_valid_i(seq_v), .eg_seq_i(seq), .ig_class_drop_i(dev[0]),
      .ig_consist_drop_i(dev[1]), .ig_post_drop_i(dev[2]), .ig_mtu_drop_i(dev[3]),
      .eg_class_drop_i(dev[4]), .eg_post_drop_i(dev[5]), .eg_mtu_drop_i(dev[6]),
      .rec_ctx_o(rec_ctx_o), .rec_rd_o(rec_rd_o), .rec_seq_i(rec_seq_i),
      .rec_wr_o(rec_wr_o), .rec_seq_o(rec_seq_o), .stat_clear_on_read_o(cor_o),
      .stat_saturate_o(sat_o), .core_irq_o(core_irq_o), .ig_irq_o(ig_irq_o),
      .eg_irq_o(eg_irq_o), .irq_o(irq_o));
   task automatic end_sim();
      if (err_count == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", n, exp, seen);
      end
   endtask
   // Ends 1 ns past the taking edge so register-fed levels have settled
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      #1;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      chk("rdata_o", rdata_o & m, e);
   endtask
   task automatic ev(input logic [5:0] c, input logic [6:0] d, input logic [31:0] s, input logic v);
      @(posedge clk_i);
      cev <= c;
      dev <= d;
      seq <= s;
      seq_v <= v;
      @(posedge clk_i);
      cev <= 6'h0;
      dev <= 7'h0;
      seq_v <= 1'b0;
      #1;
   endtask
   // Stored number held still across the whole update so the compare is unambiguous
   task automatic upd(input logic [31:0] lo, input logic [31:0] c, input logic [63:0] st,
      input logic w, input logic [63:0] e);
      logic seen;
      logic [63:0] s;
      seen = 0;
      s = 64'h0;
      @(posedge clk_i);
      rec_seq_i <= st;
      wr(8'h14, lo);
      wr(8'h20, c);
      chk("rec_rd_o", rec_rd_o, 1'b1);
      repeat (6)
      begin
         @(posedge clk_i);
         #1;
         if (rec_wr_o)
            s = rec_seq_o;
         seen = seen | rec_wr_o;
      end
      chk("rec_wr_o", seen, w);
      if (w)
         chk("rec_seq_o", s, e);
      rdc(8'h20, 32'h0, 32'h1);
   endtask
   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 4000)
      begin
         err_count++;
         end_sim();
      end
   end
   initial
   begin
      repeat (6) @(posedge clk_i);
      nrst_i <= 1'b1;
      wr(8'h40, 32'hffffffff);
      rdc(8'h40, 32'h0);
      rdc(8'h04, 32'h0);
      for (int k = 0; k < 6; k++)
      begin
         ev(6'h1 << k, 7'h0, 32'h0, 1'b0);
         rdc(8'h00, 32'h1 << cb[k]);
         wr(8'h00, 32'h1 << cb[k]);
         rdc(8'h00, 32'h0);
      end
      wr(8'h08, 32'hf0000000);
      ev(6'h0, 7'h0, 32'hf0000000, 1'b1);
      rdc(8'h00, 32'h0);
      ev(6'h0, 7'h0, 32'hf0000001, 1'b1);
      rdc(8'h00, 32'h10);
      chk("irq_o", irq_o, 1'b0);
      wr(8'h04, 32'h10);
      chk("irqs", {core_irq_o, ig_irq_o, eg_irq_o, irq_o}, 4'hf);
      wr(8'h04, 32'h0);
      chk("irq_o", irq_o, 1'b0);
      wr(8'h00, 32'h10);
      wr(8'h04, 32'h10);
      chk("irq_o", irq_o, 1'b0);
      wr(8'h10, 32'h70f);
      for (int k = 0; k < 7; k++)
      begin
         ev(6'h0, 7'h1 << k, 32'h0, 1'b0);
         rdc(8'h0c, 32'h1 << db[k]);
         chk("path irq", {ig_irq_o, eg_irq_o}, (k < 4) ? 2'b10 : 2'b01);
         wr(8'h0c, 32'h1 << db[k]);
      end
      wr(8'h18, 32'h1);
      wr(8'h1c, 32'h5a);
      upd(32'h10, 32'h3, 64'h1_0000_000f, 1'b1, 64'h1_0000_0010);
      chk("rec_ctx_o", rec_ctx_o, 8'h5a);
      upd(32'h20, 32'h1, 64'h20, 1'b0, 64'h0);
      upd(32'h20, 32'h1, 64'h1f, 1'b1, 64'h20);
      wr(8'h24, 32'h3);
      chk("stat cfg", {cor_o, sat_o}, 2'b11);
      end_sim();
   end
endmodule
